/* bench/test_or_into_target_execute.sv */
// self-checking bench for the or-into-target execute slice
`timescale 1ns/1ps
module test_or_into_target_execute
  import oit_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] a;
    logic       z;
    oit_wr_t    w;
  } oit_note_t;
  logic              core_clk = 0;
  logic              srst = 1;
  logic [INSN_W-1:0] insn = '0;
  logic [DATA_W-1:0] rf_rdata = '0;
  logic [ADDR_W-1:0] rf_raddr;
  oit_wr_t           rf_wr;
  logic [DATA_W-1:0] acc;
  logic              zero_flag;
  oit_phase_t        phase;
  oit_note_t         q[$];
  oit_note_t         m = '0;
  oit_note_t         n;
  int                bad_count = 0;
  int                check_count = 0;
  int                seed = 32'h16E5DAF2;
  logic              was_wr = 0;

  oit_execute u_oit_execute (.core_clk(core_clk), .srst(srst), .insn(insn),
    .rf_rdata(rf_rdata), .rf_raddr(rf_raddr), .rf_wr(rf_wr), .acc(acc),
    .zero_flag(zero_flag), .phase(phase));

  // ==========
  // clock, compare and verdict
  initial forever #2.5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one instruction per four phases; note kept on the model's state
  task automatic issue(input int k, input logic d, input logic [7:0] v);
    logic [7:0] r;
    logic [6:0] f;
    f = 7'($random(seed));
    check(phase, PH_DECODE);
    insn = k == 0 ? {OP_IOR, d, f} : k == 1 ? {OP_COPY, d, f}
                  : {OP_LIT, 2'h3, v};
    m.w.en = 1'h0;
    @(negedge core_clk);
    rf_rdata = v;
    if (k != 2)
      check(rf_raddr, f);
    r = k == 0 ? (m.a | v) : v;
    if (k == 2)
      m.a = v;
    else
    begin
      m.z = r == 8'h00;
      if (d)
        m.w = {1'h1, f, r};
      else
        m.a = r;
    end
    q.push_back(m);
    repeat (3) @(negedge core_clk);
  endtask

  // monitor: result lands on the edge that leaves the write phase
  always @(negedge core_clk)
  begin
    if (was_wr)
    begin
      n = q.size() > 0 ? q.pop_front() : '1;
      check(acc, n.a);
      check(zero_flag, n.z);
      check(rf_wr.en, n.w.en);
      if (n.w.en)
        check({rf_wr.addr, rf_wr.data}, {n.w.addr, n.w.data});
    end
    was_wr = phase === PH_WRITE;
  end

  // first few force zero results so the flag is exercised
  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    srst = 0;
    for (int i = 0; i < 60; i++)
      issue(i < 3 ? i : $unsigned($random(seed)) % 3, 1'($random(seed)),
            i < 4 ? 8'h00 : 8'($random(seed)));
    // let the monitor take the last note before the queue is judged
    @(posedge core_clk);
    check(q.size(), 0);
    results();
  end

  initial
  begin
    #20000;
    bad_count++;
    results();
  end
endmodule

/* logic/oit_execute.sv */
// or-into-target execute slice with literal load and register copy
`timescale 1ns/1ps
// Summary of operation
// - OR operation combines accumulator and addressed file register bitwise.
// - Target bit zero: result to accumulator, file register untouched.
// - Target bit one: result written back to addressed file register.
// - Decode opcode 00 0100 d fff ffff; zero flag follows result.
// - Register address is seven bits, 0..127; target bit is 0 or 1.
module oit_execute
  import oit_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic [DATA_W-1:0] rf_rdata,
  output logic      [ADDR_W-1:0] rf_raddr,
  output oit_wr_t                rf_wr,
  output logic      [DATA_W-1:0] acc,
  output logic                   zero_flag,
  output oit_phase_t             phase
);

  // ==========================================================
  // decode
  // ==========================================================
  // instruction is sampled at decode so a mid-cycle change is harmless
  // all decode below reads the held word, never the live input, so the
  // feeding stage may move on to the next word once decode has passed
  // unknown opcodes fall through every select: no write, flags kept
  logic [INSN_W-1:0] ir;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] result;
  oit_phase_t        next_phase;

  wire              is_ior   = ir[OP_HI:OP_LO] == OP_IOR;
  wire              is_copy  = ir[OP_HI:OP_LO] == OP_COPY;
  wire              is_lit   = ir[OP_HI:LIT_OP_LO] == OP_LIT;
  wire              dest     = ir[DEST_BIT];
  wire [ADDR_W-1:0] f_addr   = ir[ADDR_W-1:0];
  wire [DATA_W-1:0] lit      = ir[DATA_W-1:0];
  wire [DATA_W-1:0] or_val   = acc | opnd;
  wire              wr_reg   = (is_ior | is_copy) & (dest == DEST_REG);
  wire              wr_acc   = ((is_ior | is_copy) & (dest == DEST_ACC))
                               | is_lit;

  // ==========================================================
  // phase sequencer
  // ==========================================================
  // free-running four-phase ring; one instruction per lap, no stalls
  // an illegal code falls back to decode rather than locking up
  always_comb
  begin
    case (phase)
      PH_DECODE:  next_phase = PH_READ;
      PH_READ:    next_phase = PH_PROCESS;
      PH_PROCESS: next_phase = PH_WRITE;
      PH_WRITE:   next_phase = PH_DECODE;
      default:    next_phase = PH_DECODE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      phase <= PH_DECODE;
    else
      phase <= next_phase;
  end

  // ==========================================================
  // datapath: latch insn, read f, process, write destination
  // ==========================================================
  // read address is latched from the live word at decode so the file
  // register answers in time for the read phase; the operand is then
  // held so the file may change under us during process and write
  // result is registered to keep the write-back path short
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ir       <= '0;
      rf_raddr <= '0;
      opnd     <= ZERO_B;
      result   <= ZERO_B;
    end
    else
    begin
      if (phase == PH_DECODE)
      begin
        ir       <= insn;
        rf_raddr <= insn[ADDR_W-1:0];
      end
      if (phase == PH_READ)
        opnd <= rf_rdata;
      if (phase == PH_PROCESS)
        result <= is_ior ? or_val : (is_lit ? lit : opnd);
    end
  end

  // write-back phase; write strobe is one clock wide
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      acc       <= ACC_RST;
      zero_flag <= 1'b0;
      rf_wr     <= '0;
    end
    else
    begin
      rf_wr.en <= 1'b0;
      if (phase == PH_WRITE)
      begin
        if (wr_acc)
          acc <= result;
        if (wr_reg)
        begin
          rf_wr.en   <= 1'b1;
          rf_wr.addr <= f_addr;
          rf_wr.data <= result;
        end
        // literal load leaves flags alone
        if (is_ior | is_copy)
          zero_flag <= (result == ZERO_B);
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  ior_acc_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_ior && dest == DEST_ACC)
    |=> (acc == ($past(acc) | $past(opnd))) && !rf_wr.en)
    else $error("or to accumulator wrong");

  ior_reg_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_ior && dest == DEST_REG)
    |=> rf_wr.en && rf_wr.addr == $past(f_addr)
        && rf_wr.data == ($past(acc) | $past(opnd)) && $stable(acc))
    else $error("or to register wrong");

  or_result_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_PROCESS && is_ior) |=> result == ($past(acc) | $past(opnd)))
    else $error("or result wrong");

  zero_upd_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_ior)
    |=> zero_flag == (($past(acc) | $past(opnd)) == ZERO_B))
    else $error("zero flag wrong");

  addr_lat_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_DECODE) |=> ##1 rf_raddr == $past(insn[ADDR_W-1:0], 2))
    else $error("address not latched");

  lit_load_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_lit)
    |=> acc == $past(lit) && $stable(zero_flag) && !rf_wr.en)
    else $error("literal load wrong");

  // ----------------------------------------------------------
  // register copy, refused words and sequencing
  // ----------------------------------------------------------
  // copy to accumulator: operand lands, flag follows it, no file write
  copy_acc_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_copy && dest == DEST_ACC)
    |=> acc == $past(opnd) && zero_flag == ($past(opnd) == ZERO_B)
        && !rf_wr.en)
    else $error("copy to accumulator wrong");

  // copy to file: written back to the same address it was read from
  copy_reg_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && is_copy && dest == DEST_REG)
    |=> rf_wr.en && rf_wr.addr == $past(f_addr)
        && rf_wr.data == $past(opnd) && $stable(acc))
    else $error("copy to register wrong");

  // a word that decodes to nothing must leave accumulator, flag and file write alone
  refuse_op_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE && !is_ior && !is_copy && !is_lit)
    |=> !rf_wr.en && $stable(acc) && $stable(zero_flag))
    else $error("unknown opcode changed state");

  // file write strobe never stretches over two clocks
  wr_pulse_a : assert property (@(posedge core_clk) disable iff (srst)
    rf_wr.en |=> !rf_wr.en)
    else $error("write strobe too long");

  // exactly one phase active at all times
  phase_hot_a : assert property (@(posedge core_clk) disable iff (srst)
    $onehot(phase))
    else $error("phase not one-hot");

  // every instruction completes in one four-phase cycle
  phase_step_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase == PH_WRITE) |=> phase == PH_DECODE)
    else $error("phase did not wrap");

  // accumulator and flag only move on the edge leaving write
  acc_hold_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase != PH_WRITE) |=> $stable(acc) && $stable(zero_flag))
    else $error("state changed outside write");

  // no file write can start outside the write phase
  wr_window_a : assert property (@(posedge core_clk) disable iff (srst)
    (phase != PH_WRITE) |=> !rf_wr.en)
    else $error("file write outside write phase");

endmodule

/* logic/oit_pkg.sv */
// package of constants and types for the or-into-target execute slice
package oit_pkg;
  // instruction word layout (14-bit)
  localparam int INSN_W    = 14;
  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 8;
  localparam int OP_HI     = 13;
  localparam int OP_LO     = 8;
  localparam int DEST_BIT  = 7;
  localparam int LIT_OP_LO = 10;
  // opcode fields
  localparam logic [5:0] OP_IOR   = 6'h04;
  localparam logic [5:0] OP_COPY  = 6'h08;
  localparam logic [3:0] OP_LIT   = 4'hC;
  localparam logic       DEST_ACC = 1'h0;
  localparam logic       DEST_REG = 1'h1;
  // reset values
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] ZERO_B   = 8'h00;

  // four-phase instruction cycle, one-hot
  typedef enum logic [3:0]
  {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } oit_phase_t;

  // register file write request
  typedef struct packed
  {
    logic             en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } oit_wr_t;
endpackage
